/* esr_regs.sv */
// Evaluation stack register set with workspace, instruction and operand registers.
// Assumes execution control drives one request per clock and keeps depth within three.
`timescale 1ns/1ps
`include "esr_params.svh"
module esr_regs #(
    parameter int ONCHIP_BYTES = `ESR_ONCHIP_BYTES,
    parameter int EXT_BYTES    = `ESR_EXT_BYTES
) (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic [7:0]           instr_byte,
    input  wire logic                 instr_valid,
    input  wire esr_pkg::esr_opr_op_e opr_op,
    input  wire esr_pkg::esr_stk_op_e stk_op,
    input  wire logic [15:0]          stk_data,
    input  wire esr_pkg::esr_base_e   addr_base,
    input  wire logic                 iptr_load,
    input  wire logic [15:0]          iptr_value,
    input  wire logic                 wptr_load,
    input  wire logic [15:0]          wptr_value,
    output logic [3:0]                func_code,
    output logic [15:0]               top,
    output logic [15:0]               second,
    output logic [15:0]               third,
    output logic [15:0]               operand,
    output logic [15:0]               iptr,
    output logic [15:0]               wptr,
    output logic [15:0]               mem_addr,
    output logic                      mem_onchip
);
    esr_pkg::esr_word_t next_top;
    esr_pkg::esr_word_t next_second;
    esr_pkg::esr_word_t next_third;
    esr_pkg::esr_word_t next_addr;
    esr_opr_if          opr ();

    // Onchip window decode, used for the address output
    function automatic logic is_onchip(input esr_pkg::esr_word_t a);
        is_onchip = ({16'h0000, a} < 32'(ONCHIP_BYTES));
    endfunction

    // Low nibble of the instruction byte goes to the operand builder
    assign opr.nibble = instr_byte[3:0];
    assign opr.op     = instr_valid ? opr_op : esr_pkg::ESR_OPR_NONE;

    esr_operand u_operand (
        .clock (clock),
        .reset (reset),
        .opr   (opr.unit)
    );

    // Next stack values; depth beyond three just falls off the bottom
    always_comb begin
        next_top    = top;
        next_second = second;
        next_third  = third;
        case (stk_op)
            esr_pkg::ESR_STK_PUSH: begin
                next_third  = second;
                next_second = top;
                next_top    = stk_data;
            end
            esr_pkg::ESR_STK_POP: begin
                next_top    = second;
                next_second = third;
            end
            esr_pkg::ESR_STK_ADD: begin
                // Third stays put; generated code must not rely on its value
                next_top    = top + second;
                next_second = third;
            end
            esr_pkg::ESR_STK_WRITE_TOP: begin
                next_top = stk_data;
            end
            default: begin
                next_top = top;
            end
        endcase
    end

    // All three stack registers load their next values on one edge, even those the operation leaves unchanged
    always_ff @(posedge clock) begin
        if (reset) begin
            top    <= `ESR_RESET_WORD;
            second <= `ESR_RESET_WORD;
            third  <= `ESR_RESET_WORD;
        end else begin
            top    <= next_top;
            second <= next_second;
            third  <= next_third;
        end
    end

    // Instruction pointer: jump load wins, else step past each byte
    always_ff @(posedge clock) begin
        if (reset) begin
            iptr <= `ESR_RESET_WORD;
        end else if (iptr_load) begin
            iptr <= iptr_value;
        end else if (instr_valid) begin
            iptr <= iptr + 16'h0001;
        end
    end

    // Workspace pointer
    always_ff @(posedge clock) begin
        if (reset) begin
            wptr <= `ESR_RESET_WORD;
        end else if (wptr_load) begin
            wptr <= wptr_value;
        end
    end

    // Address uses the operand as it stands before this instruction finishes
    always_comb begin
        case (addr_base)
            esr_pkg::ESR_BASE_LOCAL:     next_addr = wptr + {opr.operand[14:0], 1'b0};
            esr_pkg::ESR_BASE_NON_LOCAL: next_addr = top + {opr.operand[14:0], 1'b0};
            default:                     next_addr = mem_addr;
        endcase
    end

    // Registered outputs; wrap-around on the sum is the full 16-bit space
    always_ff @(posedge clock) begin
        if (reset) begin
            mem_addr   <= `ESR_RESET_WORD;
            mem_onchip <= 1'b1;
            func_code  <= 4'h0;
            operand    <= `ESR_RESET_WORD;
        end else begin
            mem_addr   <= next_addr;
            mem_onchip <= is_onchip(next_addr);
            func_code  <= instr_valid ? instr_byte[7:4] : func_code;
            operand    <= opr.next_operand;
        end
    end

    // Stack movement checks
    AST_PUSH_SHIFT: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_PUSH |=>
        third == $past(second) && second == $past(top) && top == $past(stk_data))
        else $error("push did not shift stack");
    AST_POP_SHIFT: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_POP |=> top == $past(second) && second == $past(third))
        else $error("pop did not shift stack");
    AST_ADD_TOP: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_ADD |=> top == 16'($past(top) + $past(second)))
        else $error("add result wrong");
    AST_ADD_DROP: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_ADD |=> second == $past(third) && $stable(third))
        else $error("add did not close up the stack");
    AST_WRITE_TOP: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_WRITE_TOP |=> top == $past(stk_data) && $stable(second) && $stable(third))
        else $error("top write disturbed the stack");
    AST_HOLD_STACK: assert property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_HOLD |=> $stable(top) && $stable(second) && $stable(third))
        else $error("stack moved while idle");

    // Pointer and function code checks
    AST_IPTR_STEP: assert property (@(posedge clock) disable iff (reset)
        instr_valid && !iptr_load |=> iptr == 16'($past(iptr) + 16'h0001))
        else $error("instruction pointer not advanced");
    AST_IPTR_LOAD: assert property (@(posedge clock) disable iff (reset)
        iptr_load |=> iptr == $past(iptr_value))
        else $error("instruction pointer jump lost");
    AST_IPTR_HOLD: assert property (@(posedge clock) disable iff (reset)
        !iptr_load && !instr_valid |=> $stable(iptr))
        else $error("instruction pointer moved without an instruction");
    AST_WPTR_LOAD: assert property (@(posedge clock) disable iff (reset)
        wptr_load |=> wptr == $past(wptr_value))
        else $error("workspace pointer load lost");
    AST_WPTR_HOLD: assert property (@(posedge clock) disable iff (reset)
        !wptr_load |=> $stable(wptr))
        else $error("workspace pointer moved without a load");
    AST_FUNC_CODE: assert property (@(posedge clock) disable iff (reset)
        instr_valid |=> func_code == $past(instr_byte[7:4]))
        else $error("function code not taken from upper nibble");

    // Address and operand output checks
    AST_LOCAL_ADDR: assert property (@(posedge clock) disable iff (reset)
        addr_base == esr_pkg::ESR_BASE_LOCAL |=>
        mem_addr == 16'($past(wptr) + {$past(opr.operand[14:0]), 1'b0}))
        else $error("local address wrong");
    AST_NONLOCAL_ADDR: assert property (@(posedge clock) disable iff (reset)
        addr_base == esr_pkg::ESR_BASE_NON_LOCAL |=>
        mem_addr == 16'($past(top) + {$past(opr.operand[14:0]), 1'b0}))
        else $error("non-local address wrong");
    AST_ADDR_HOLD: assert property (@(posedge clock) disable iff (reset)
        addr_base == esr_pkg::ESR_BASE_NONE |=> $stable(mem_addr) && $stable(mem_onchip))
        else $error("address moved without a request");
    AST_ONCHIP: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> mem_onchip == (32'(mem_addr) < 32'(ONCHIP_BYTES)))
        else $error("onchip flag wrong");
    AST_OPERAND_MIRROR: assert property (@(posedge clock) disable iff (reset)
        1'b1 |-> operand == opr.operand)
        else $error("operand output lags register");

    // Reset must leave every register at its start value one edge later
    AST_RESET_CLEAR: assert property (@(posedge clock) reset |=>
        top == 16'h0000 && second == 16'h0000 && third == 16'h0000 &&
        operand == 16'h0000 && iptr == 16'h0000 && wptr == 16'h0000 &&
        mem_addr == 16'h0000 && mem_onchip == 1'b1 && func_code == 4'h0)
        else $error("register not cleared by reset");

    // Main scenarios
    COV_JUMP: cover property (@(posedge clock) disable iff (reset)
        iptr_load && instr_valid);
    COV_PUSH3: cover property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_PUSH [*3]);
    COV_ADD_AFTER_PUSH: cover property (@(posedge clock) disable iff (reset)
        stk_op == esr_pkg::ESR_STK_PUSH ##1 stk_op == esr_pkg::ESR_STK_ADD);
    COV_NONLOCAL: cover property (@(posedge clock) disable iff (reset)
        addr_base == esr_pkg::ESR_BASE_NON_LOCAL);
endmodule

/* esr_params.svh */
// Constants for the evaluation stack register set.
// Included by its bare name; holds definitions only.
`ifndef ESR_PARAMS_SVH
`define ESR_PARAMS_SVH
`define ESR_WORD_W        16
`define ESR_NIBBLE_W      4
`define ESR_RESET_WORD    16'h0000
`define ESR_ONCHIP_BYTES  4096
`define ESR_EXT_BYTES     65536
`endif

/* esr_pkg.sv */
// Types shared by the evaluation stack register set.
// Assumes esr_params.svh is available on the include path.
`include "esr_params.svh"
package esr_pkg;
    typedef logic [`ESR_WORD_W-1:0] esr_word_t;
    // Stack operation requested by execution control
    typedef enum logic [2:0] {
        ESR_STK_HOLD,
        ESR_STK_PUSH,
        ESR_STK_POP,
        ESR_STK_ADD,
        ESR_STK_WRITE_TOP
    } esr_stk_op_e;
    // Operand register action for one instruction
    typedef enum logic [1:0] {
        ESR_OPR_NONE,
        ESR_OPR_PLAIN,
        ESR_OPR_PREFIX,
        ESR_OPR_NEG_PREFIX
    } esr_opr_op_e;
    // Base used to form a memory address
    typedef enum logic [1:0] {
        ESR_BASE_NONE,
        ESR_BASE_LOCAL,
        ESR_BASE_NON_LOCAL
    } esr_base_e;
endpackage

/* esr_opr_if.sv */
// Interface between the register set and its operand builder.
// Assumes one clock; carries the nibble request and the operand value.
`timescale 1ns/1ps
interface esr_opr_if;
    esr_pkg::esr_opr_op_e op;
    logic [3:0]           nibble;
    esr_pkg::esr_word_t   operand;
    esr_pkg::esr_word_t   next_operand;
    modport ctrl (output op, output nibble, input operand, input next_operand);
    modport unit (input op, input nibble, output operand, output next_operand);
endinterface

/* esr_operand.sv */
// Operand register builder: nibble load, prefix shift, clear on finish.
// Assumes the requester presents one action per clock, NONE when idle.
`timescale 1ns/1ps
`include "esr_params.svh"
module esr_operand (
    input  wire logic clock,
    input  wire logic reset,
    esr_opr_if.unit   opr
);
    esr_pkg::esr_word_t loaded;

    // Data nibble sits in the low bits before any shift
    assign loaded = {opr.operand[`ESR_WORD_W-1:`ESR_NIBBLE_W], opr.nibble};

    // Prefixes keep the value shifted up, negative prefix inverted first; plain instructions leave it clear
    always_comb begin
        case (opr.op)
            esr_pkg::ESR_OPR_PREFIX:     opr.next_operand = loaded << `ESR_NIBBLE_W;
            esr_pkg::ESR_OPR_NEG_PREFIX: opr.next_operand = (~loaded) << `ESR_NIBBLE_W;
            esr_pkg::ESR_OPR_PLAIN:      opr.next_operand = `ESR_RESET_WORD;
            default:                     opr.next_operand = opr.operand;
        endcase
    end

    // Operand register
    always_ff @(posedge clock) begin
        if (reset) begin
            opr.operand <= `ESR_RESET_WORD;
        end else begin
            opr.operand <= opr.next_operand;
        end
    end

    AST_PREFIX_SHIFT: assert property (@(posedge clock) disable iff (reset)
        opr.op == esr_pkg::ESR_OPR_PREFIX |=> opr.operand[3:0] == 4'h0)
        else $error("prefix left low nibble set");
    AST_PLAIN_CLEAR: assert property (@(posedge clock) disable iff (reset)
        opr.op == esr_pkg::ESR_OPR_PLAIN |=> opr.operand == 16'h0000)
        else $error("operand not cleared after instruction");
    AST_NEG_LOW: assert property (@(posedge clock) disable iff (reset)
        opr.op == esr_pkg::ESR_OPR_NEG_PREFIX |=>
        opr.operand[7:4] == ~$past(opr.nibble))
        else $error("negative prefix nibble wrong");
    COV_PREFIX_CHAIN: cover property (@(posedge clock) disable iff (reset)
        opr.op == esr_pkg::ESR_OPR_PREFIX ##1 opr.op == esr_pkg::ESR_OPR_PLAIN);
endmodule

/* esr_decode_model.sv */
// Stand-in for the instruction decoder that drives the register set.
// Assumes the instruction byte is settled before the edge that takes it.
`timescale 1ns/1ps
module esr_decode_model #(
    parameter logic [3:0] PREFIX_FN     = 4'h2, // Default prefix code
    parameter logic [3:0] NEG_PREFIX_FN = 4'h6  // Default negative prefix code
) (
    input  wire logic [7:0]      instr_byte,
    input  wire logic            instr_valid,
    output esr_pkg::esr_opr_op_e opr_op
);
    // Upper nibble picks the operand action; only prefixes keep the operand
    always_comb begin
        if (!instr_valid)
            opr_op = esr_pkg::ESR_OPR_NONE;
        else if (instr_byte[7:4] == PREFIX_FN)
            opr_op = esr_pkg::ESR_OPR_PREFIX;
        else if (instr_byte[7:4] == NEG_PREFIX_FN)
            opr_op = esr_pkg::ESR_OPR_NEG_PREFIX;
        else
            opr_op = esr_pkg::ESR_OPR_PLAIN;
    end
endmodule

/* testbench.sv */
// Random-traffic bench comparing the register set with a cycle model.
// Assumes a single 100 MHz clock and synchronous active high reset.
`timescale 1ns/1ps
`define ESR_CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
    $display("ERROR %0t: output differs from model", $time); end end
module testbench;
    localparam int         CYCLES = 1500;
    localparam int         ONCHIP = 4096;
    localparam logic [3:0] PFX    = 4'h2;
    localparam logic [3:0] NFX    = 4'h6;
    logic                  clock = 1'b0;
    logic                  reset = 1'b1;
    logic [7:0]            instr_byte = 8'h00;
    logic                  instr_valid = 1'b0;
    esr_pkg::esr_opr_op_e  opr_op;
    esr_pkg::esr_stk_op_e  stk_op = esr_pkg::ESR_STK_HOLD;
    logic [15:0]           stk_data = 16'h0000;
    esr_pkg::esr_base_e    addr_base = esr_pkg::ESR_BASE_NONE;
    logic                  iptr_load = 1'b0;
    logic [15:0]           iptr_value = 16'h0000;
    logic                  wptr_load = 1'b0;
    logic [15:0]           wptr_value = 16'h0000;
    logic [3:0]            func_code;
    logic [15:0]           top, second, third, operand, iptr, wptr, mem_addr;
    logic                  mem_onchip;
    logic [15:0]           op, ld, ip, wp, ma, sm;
    logic [15:0]           stk[$];
    logic [3:0]            fc;
    int                    error_cnt = 0;
    int                    check_count = 0;
    int                    seed = 32'ha351_3676;
    logic [31:0]           r;

    esr_decode_model #(.PREFIX_FN(PFX), .NEG_PREFIX_FN(NFX)) esr_decode_model_i (
        .instr_byte(instr_byte), .instr_valid(instr_valid), .opr_op(opr_op));
    esr_regs #(.ONCHIP_BYTES(ONCHIP)) esr_regs_i (
        .clock(clock), .reset(reset), .instr_byte(instr_byte), .instr_valid(instr_valid),
        .opr_op(opr_op), .stk_op(stk_op), .stk_data(stk_data), .addr_base(addr_base),
        .iptr_load(iptr_load), .iptr_value(iptr_value), .wptr_load(wptr_load),
        .wptr_value(wptr_value), .func_code(func_code), .top(top), .second(second),
        .third(third), .operand(operand), .iptr(iptr), .wptr(wptr), .mem_addr(mem_addr),
        .mem_onchip(mem_onchip));

    // Free running 10 ns clock
    initial begin
        forever #5 clock = ~clock;
    end

    // Model step; address uses values from before the edge, so it goes first
    task automatic model_step();
        if (reset) begin
            {op, ip, wp, ma, fc} = '0;
            stk.delete();
            repeat (3) stk.push_back(16'h0000);
        end else begin
            if (addr_base == esr_pkg::ESR_BASE_LOCAL) ma = wp + (op << 1);
            if (addr_base == esr_pkg::ESR_BASE_NON_LOCAL) ma = stk[0] + (op << 1);
            // Stack kept as a three-entry queue, index 0 is the top
            case (stk_op)
                esr_pkg::ESR_STK_PUSH: begin
                    stk.push_front(stk_data);
                    void'(stk.pop_back());
                end
                esr_pkg::ESR_STK_POP: begin
                    void'(stk.pop_front());
                    stk.push_back(stk[1]);
                end
                esr_pkg::ESR_STK_ADD: begin
                    sm = 16'(stk[0] + stk[1]);
                    void'(stk.pop_front());
                    stk[0] = sm;
                    stk.push_back(stk[1]);
                end
                esr_pkg::ESR_STK_WRITE_TOP: stk[0] = stk_data;
                default: ;
            endcase
            if (instr_valid) begin
                fc = instr_byte[7:4];
                ld = {op[15:4], instr_byte[3:0]};
                if (opr_op == esr_pkg::ESR_OPR_PLAIN) op = 16'h0000;
                if (opr_op == esr_pkg::ESR_OPR_PREFIX) op = ld << 4;
                if (opr_op == esr_pkg::ESR_OPR_NEG_PREFIX) op = (~ld) << 4;
            end
            if (iptr_load) ip = iptr_value;
            else if (instr_valid) ip = ip + 16'h0001;
            if (wptr_load) wp = wptr_value;
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard sized from the planned cycle count
    initial begin
        #(CYCLES * 10 + 1000);
        error_cnt++;
        conclude();
    end

    // Random stimulus; prefixes are biased so long operand chains occur
    initial begin
        for (int i = 0; i < CYCLES; i++) begin
            @(posedge clock);
            model_step();
            r = $random(seed);
            reset       <= (i < 4) || (i >= 700 && i < 703);
            instr_valid <= r[16];
            instr_byte  <= r[17] ? {(r[18] ? PFX : NFX), r[3:0]} : r[15:8];
            stk_op      <= esr_pkg::esr_stk_op_e'(3'($unsigned($random(seed)) % 5));
            stk_data    <= 16'($random(seed));
            addr_base   <= esr_pkg::esr_base_e'(2'($unsigned($random(seed)) % 3));
            iptr_load   <= (r[23:20] == 4'h0);
            iptr_value  <= 16'($random(seed));
            wptr_load   <= r[24];
            wptr_value  <= 16'h0ff0 + 16'(r[29:25]); // Straddles the on-chip limit
            @(negedge clock);
            `ESR_CHK(top, stk[0])
            `ESR_CHK(second, stk[1])
            `ESR_CHK(third, stk[2])
            `ESR_CHK(func_code, fc)
            `ESR_CHK(operand, op)
            `ESR_CHK(iptr, ip)
            `ESR_CHK(wptr, wp)
            `ESR_CHK(mem_addr, ma)
            `ESR_CHK(mem_onchip, (int'(ma) < ONCHIP))
        end
        conclude();
    end
endmodule
